// [bench/locked_transaction_bridge_tb_top.sv]
// self-checking bench for bridge end and far end joined by the link
`timescale 1ns/1ps
`default_nettype none
module locked_transaction_bridge_tb_top;
  typedef struct packed {
    logic [31:0] a;
    logic        w;
    logic        x;
    logic        p;
  } ltb_row_t;
  logic mclk, srst, lock_route_sel, lock_go, lock_done, lock_owned;
  logic cmd_valid, cmd_write, cmd_excl, cmd_busy, cmd_ack, cmd_retry;
  logic fwd_valid, fwd_write, fwd_locked, fwd_posted, post_en, lock_active;
  logic complete_lock, cache_req, cache_gnt, card_lock;
  logic [31:0] cmd_addr, fwd_addr;
  logic [27:0] region;
  logic [1:0] agent_req, agent_gnt;
  int bad_count, checked, cycles;
  ltb_row_t rows [4] = '{'{32'h0000_0100, 1'b1, 1'b0, 1'b1}, '{32'h0000_0104, 1'b0, 1'b0, 1'b0},
                         '{32'h0000_1ff0, 1'b1, 1'b1, 1'b1}, '{32'hffff_fffc, 1'b0, 1'b1, 1'b0}};
  // ****************************************
  // design and checker
  // ****************************************
  ltb_if ltb_if_i (.mclk(mclk), .srst(srst));
  ltb_bridge ltb_bridge_i (.lnk(ltb_if_i), .lock_route_sel(lock_route_sel), .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr), .fwd_write(fwd_write), .fwd_locked(fwd_locked), .fwd_posted(fwd_posted),
    .post_en(post_en), .lock_active(lock_active), .region(region));
  ltb_host ltb_host_i (.lnk(ltb_if_i), .lock_go(lock_go), .lock_done(lock_done), .lock_owned(lock_owned),
    .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_write(cmd_write), .cmd_excl(cmd_excl),
    .cmd_busy(cmd_busy), .cmd_ack(cmd_ack), .cmd_retry(cmd_retry), .complete_lock(complete_lock),
    .agent_req(agent_req), .cache_req(cache_req), .agent_gnt(agent_gnt), .cache_gnt(cache_gnt),
    .card_lock(card_lock));
  ltb_chk ltb_chk_i (.mclk(ltb_if_i.mclk), .srst(ltb_if_i.srst), .host_lock_o(ltb_if_i.host_lock_o),
    .host_lock_oe(ltb_if_i.host_lock_oe), .lock_n(ltb_if_i.lock_n), .dev_cblock_o(ltb_if_i.dev_cblock_o),
    .dev_cblock_oe(ltb_if_i.dev_cblock_oe), .cblock_n(ltb_if_i.cblock_n), .tr_valid(ltb_if_i.tr_valid),
    .tr_addr(ltb_if_i.tr_addr), .tr_excl(ltb_if_i.tr_excl), .tr_ack(ltb_if_i.tr_ack),
    .tr_retry(ltb_if_i.tr_retry));
  // ****************************************
  // clock, timeout, helpers
  // ****************************************
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      results();
    end
  end
  task automatic results();
    if (bad_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (exp !== got) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic lock_pulse(input logic rel);
    @(posedge mclk);
    lock_go   <= !rel;
    lock_done <= rel;
    @(posedge mclk);
    lock_go   <= 1'b0;
    lock_done <= 1'b0;
    #1;
  endtask
  task automatic wait_own(input logic v);
    int n;
    n = 0;
    while (lock_owned !== v && n < 40) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("lock_owned", v, lock_owned);
  endtask
  task automatic xfer(input logic [31:0] a, input logic w, input logic x, input logic r, input logic l,
                      input logic p);
    logic ack_seen, rty_seen, fwd_seen, busy_seen;
    ack_seen  = 1'b0;
    rty_seen  = 1'b0;
    fwd_seen  = 1'b0;
    busy_seen = 1'b0;
    @(posedge mclk);
    cmd_addr  <= a;
    cmd_write <= w;
    cmd_excl  <= x;
    cmd_valid <= 1'b1;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    for (int n = 0; n < 20 && !(ack_seen | rty_seen); n++) begin
      @(posedge mclk);
      #1;
      if (cmd_busy === 1'b1) busy_seen = 1'b1;
      if (fwd_valid === 1'b1) fwd_seen = 1'b1;
      if (cmd_ack === 1'b1) ack_seen = 1'b1;
      if (cmd_retry === 1'b1) rty_seen = 1'b1;
    end
    chk("cmd_busy", 1'b1, busy_seen);
    chk("cmd_busy", 1'b0, cmd_busy);
    chk("cmd_retry", r, rty_seen);
    chk("cmd_ack", !r, ack_seen);
    chk("fwd_valid", !r, fwd_seen);
    if (!r) begin
      chk("fwd_addr", a, fwd_addr);
      chk("fwd_write", w, fwd_write);
      chk("fwd_locked", l, fwd_locked);
      chk("fwd_posted", p, fwd_posted);
    end
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    bad_count = 0;
    checked = 0;
    cycles = 0;
    srst = 1'b1;
    {lock_route_sel, lock_go, lock_done, cmd_valid, cmd_write, cmd_excl} = 6'h00;
    {complete_lock, cache_req, card_lock, agent_req} = 5'h00;
    cmd_addr = 32'h0000_0000;
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    tick(1);
    chk("post_en", 1'b1, post_en);
    chk("lock_active", 1'b0, lock_active);
    chk("region", 28'h000_0000, region);
    foreach (rows[i]) xfer(rows[i].a, rows[i].w, rows[i].x, 1'b0, 1'b0, rows[i].p);
    lock_pulse(1'b0);
    wait_own(1'b1);
    tick(6);
    chk("post_en", 1'b1, post_en);
    xfer(32'h0000_0200, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    chk("lock_active", 1'b0, lock_active);
    lock_pulse(1'b1);
    wait_own(1'b0);
    tick(8);
    @(posedge mclk);
    card_lock <= 1'b1;
    tick(8);
    chk("lock_active", 1'b0, lock_active);
    chk("post_en", 1'b1, post_en);
    xfer(32'h0000_0100, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    @(posedge mclk);
    card_lock      <= 1'b0;
    lock_route_sel <= 1'b1;
    lock_pulse(1'b0);
    wait_own(1'b1);
    // bridge leaves idle and drops post_en one edge after the far end owns the lock
    tick(1);
    chk("post_en", 1'b0, post_en);
    xfer(32'h0000_0108, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
    chk("region", 28'h000_0010, region);
    chk("lock_active", 1'b1, lock_active);
    xfer(32'h0000_0100, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    xfer(32'h0000_010c, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    xfer(32'h0000_0110, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    xfer(32'h0000_00fc, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    @(posedge mclk);
    complete_lock <= 1'b1;
    agent_req     <= 2'b10;
    tick(2);
    chk("agent_gnt", 2'b00, agent_gnt);
    @(posedge mclk);
    cache_req <= 1'b1;
    tick(2);
    chk("cache_gnt", 1'b1, cache_gnt);
    @(posedge mclk);
    cache_req     <= 1'b0;
    complete_lock <= 1'b0;
    tick(2);
    chk("agent_gnt", 2'b10, agent_gnt);
    @(posedge mclk);
    agent_req <= 2'b00;
    lock_pulse(1'b1);
    wait_own(1'b0);
    tick(8);
    chk("post_en", 1'b1, post_en);
    chk("lock_active", 1'b0, lock_active);
    chk("region", 28'h000_0000, region);
    xfer(32'h0000_010c, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    results();
  end
endmodule
`default_nettype wire

// [bench/ltb_chk.sv]
// concurrent checks on the lock link between bridge end and far end
`timescale 1ns/1ps
`default_nettype none
module ltb_chk (
  // clock and reset
  input wire logic                       mclk,
  input wire logic                       srst,
  // lock pins
  input wire logic                       host_lock_o,
  input wire logic                       host_lock_oe,
  input wire logic                       lock_n,
  input wire logic                       dev_cblock_o,
  input wire logic                       dev_cblock_oe,
  input wire logic                       cblock_n,
  // transactions
  input wire logic                       tr_valid,
  input wire logic [ltb_pkg::ADDR_W-1:0] tr_addr,
  input wire logic                       tr_excl,
  input wire logic                       tr_ack,
  input wire logic                       tr_retry
);
  // ****************************************
  // request taken by the bridge
  // ****************************************
  logic taken;
  assign taken = tr_valid & ~tr_ack & ~tr_retry;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_answer_next: assert property (taken |=> tr_ack != tr_retry)
    else $error("no single answer one cycle after request");
  a_free_ack: assert property (taken && !dev_cblock_oe |=> tr_ack)
    else $error("request refused with no region held");
  a_retry_cause: assert property (tr_retry |-> $past(dev_cblock_oe) && !$past(tr_excl))
    else $error("retry without held region or on exclusive request");
  a_excl_ack: assert property (taken && dev_cblock_oe && tr_excl |=> tr_ack)
    else $error("exclusive request refused while lock held");
  a_lock_source: assert property ($rose(dev_cblock_oe) |-> !lock_n && !$past(lock_n, 3))
    else $error("card lock raised without settled upstream lock");
  a_lock_hold: assert property (dev_cblock_oe && !lock_n |=> dev_cblock_oe)
    else $error("card lock dropped while upstream lock held");
  a_card_pin: assert property (dev_cblock_oe |-> !dev_cblock_o && !cblock_n)
    else $error("card lock pin not low while driven");
  a_release: assert property ($rose(lock_n) ##1 (!tr_valid)[*6] |=> !dev_cblock_oe)
    else $error("card lock not released after upstream release");
  a_host_hold: assert property (taken |=> tr_valid && $stable(tr_addr) && $stable(tr_excl))
    else $error("request changed before answer");
  a_host_lock: assert property ($rose(host_lock_oe) |-> $past(lock_n) && !host_lock_o)
    else $error("lock taken while already low");
endmodule
`default_nettype wire

// [design/ltb_bridge.sv]
// bridge end: lock intake, locked region, downstream lock, posting control
// Notes on behaviour
// (RULE1) lock taken only on terminal four when routed
// (RULE2) locks carried downstream only, never upstream
// (RULE3) lock holds ownership across several transactions
// (RULE4) non-exclusive traffic outside locked region proceeds
// (RULE5) bus grant is not lock ownership
// (RULE6) other initiators may use bus during lock
// (RULE7) card side uses card lock signal
// (RULE8) lock region is aligned sixteen bytes
// (RULE9) complete-lock arbiter grants only lock master
// (RULE10) complete-lock arbiter still grants cache writeback
// (RULE11) write posting off while lock in progress
// (RULE12) full bridge lock behaviour on card path
// (RULE13) card lock gives exclusive target access
// (RULE14) release clears region, re-enables posting
`timescale 1ns/1ps
`default_nettype none
module ltb_bridge (
  // link to initiators and card
  ltb_if.dev                               lnk,
  // configuration
  input  wire logic                        lock_route_sel,
  // downstream forward path
  output logic                             fwd_valid,
  output logic [ltb_pkg::ADDR_W-1:0]       fwd_addr,
  output logic                             fwd_write,
  output logic                             fwd_locked,
  output logic                             fwd_posted,
  // status
  output logic                             post_en,
  output logic                             lock_active,
  output logic [ltb_pkg::REGION_W-1:0]     region
);

  // ****************************************************************
  // lock pin synchroniser and filter
  // ****************************************************************
  logic [ltb_pkg::SYNC_STAGES-1:0] lsync;
  logic [ltb_pkg::SYNC_STAGES-1:0] next_lsync;
  logic                            lock_level;
  logic                            next_lock_level;

  always_comb begin
    next_lsync      = {lsync[ltb_pkg::SYNC_STAGES-2:0], lnk.lock_n};
    next_lock_level = lock_level;
    if (lsync[1] == lsync[2]) begin
      next_lock_level = ~lsync[2];
    end
  end

  always_ff @(posedge lnk.mclk) begin
    if (lnk.srst) begin
      lsync      <= {ltb_pkg::SYNC_STAGES{ltb_pkg::RST_PIN}};
      lock_level <= 1'b0;
    end else begin
      lsync      <= next_lsync;
      lock_level <= next_lock_level;
    end
  end

  logic lock_req;
  assign lock_req = lock_level & lock_route_sel; // RULE1

  // ****************************************************************
  // request decode
  // ****************************************************************
  logic                         take;
  logic                         in_region;
  logic [ltb_pkg::REGION_W-1:0] req_region;

  assign take       = lnk.tr_valid & ~lnk.tr_ack & ~lnk.tr_retry;
  assign req_region = lnk.tr_addr[ltb_pkg::ADDR_W-1:ltb_pkg::GRAN_BITS]; // RULE8
  assign in_region  = (req_region == region); // RULE8

  // ****************************************************************
  // lock state
  // ****************************************************************
  ltb_pkg::ltb_dev_state_t      state;
  ltb_pkg::ltb_dev_state_t      next_state;
  logic [ltb_pkg::REGION_W-1:0] next_region;

  always_comb begin
    next_state  = state;
    next_region = region;
    case (state)
      ltb_pkg::LTB_IDLE: begin
        if (lock_req) begin
          next_state = ltb_pkg::LTB_ARMED;
        end
      end
      ltb_pkg::LTB_ARMED: begin
        if (!lock_req) begin
          next_state = ltb_pkg::LTB_IDLE;
        end else if (take && lnk.tr_excl) begin
          next_state  = ltb_pkg::LTB_HELD; // RULE3
          next_region = req_region; // RULE8
        end
      end
      ltb_pkg::LTB_HELD: begin
        if (!lock_req && !lnk.tr_valid) begin
          next_state  = ltb_pkg::LTB_IDLE; // RULE14
          next_region = ltb_pkg::RST_REGION; // RULE14
        end
      end
      default: begin
        next_state  = ltb_pkg::LTB_IDLE;
        next_region = ltb_pkg::RST_REGION;
      end
    endcase
  end

  always_ff @(posedge lnk.mclk) begin
    if (lnk.srst) begin
      state  <= ltb_pkg::LTB_IDLE;
      region <= ltb_pkg::RST_REGION;
    end else begin
      state  <= next_state;
      region <= next_region;
    end
  end

  // ****************************************************************
  // answers and downstream forwarding
  // ****************************************************************
  logic                       blocked;
  logic                       next_ack;
  logic                       next_retry;
  logic                       next_fwd_valid;
  logic [ltb_pkg::ADDR_W-1:0] next_fwd_addr;
  logic                       next_fwd_write;
  logic                       next_fwd_locked;
  logic                       next_fwd_posted;
  logic                       next_post_en;
  logic                       next_lock_active;
  logic                       next_cb_oe;
  logic                       posting;

  // foreign traffic into the held region waits; all else proceeds
  assign blocked = (state == ltb_pkg::LTB_HELD) & ~lnk.tr_excl & in_region; // RULE4
  // posting only while no lock is in progress
  assign posting = (state == ltb_pkg::LTB_IDLE) & ~lock_req; // RULE11

  always_comb begin
    next_ack         = 1'b0;
    next_retry       = 1'b0;
    next_fwd_valid   = 1'b0;
    next_fwd_addr    = fwd_addr;
    next_fwd_write   = fwd_write;
    next_fwd_locked  = fwd_locked;
    next_fwd_posted  = fwd_posted;
    next_post_en     = (next_state == ltb_pkg::LTB_IDLE) & ~lock_req; // RULE14
    next_lock_active = (next_state == ltb_pkg::LTB_HELD);
    // drive card lock only while holding a downstream lock
    next_cb_oe       = (next_state == ltb_pkg::LTB_HELD); // RULE7 RULE12 RULE13
    if (take) begin
      if (blocked) begin
        next_retry = 1'b1; // RULE4
      end else begin
        next_ack        = 1'b1; // RULE6
        next_fwd_valid  = 1'b1;
        next_fwd_addr   = lnk.tr_addr;
        next_fwd_write  = lnk.tr_write;
        next_fwd_locked = lnk.tr_excl & (state != ltb_pkg::LTB_IDLE); // RULE3
        next_fwd_posted = lnk.tr_write & posting; // RULE11
      end
    end
  end

  always_ff @(posedge lnk.mclk) begin
    if (lnk.srst) begin
      lnk.tr_ack        <= 1'b0;
      lnk.tr_retry      <= 1'b0;
      fwd_valid         <= 1'b0;
      fwd_addr          <= ltb_pkg::RST_ADDR;
      fwd_write         <= 1'b0;
      fwd_locked        <= 1'b0;
      fwd_posted        <= 1'b0;
      post_en           <= 1'b1;
      lock_active       <= 1'b0;
      lnk.dev_cblock_oe <= 1'b0;
      lnk.dev_cblock_o  <= ltb_pkg::RST_PIN;
    end else begin
      lnk.tr_ack        <= next_ack;
      lnk.tr_retry      <= next_retry;
      fwd_valid         <= next_fwd_valid;
      fwd_addr          <= next_fwd_addr;
      fwd_write         <= next_fwd_write;
      fwd_locked        <= next_fwd_locked;
      fwd_posted        <= next_fwd_posted;
      post_en           <= next_post_en;
      lock_active       <= next_lock_active;
      lnk.dev_cblock_oe <= next_cb_oe;
      // card lock is only ever pulled low by this end, never mirrored back
      lnk.dev_cblock_o  <= 1'b0; // RULE2
    end
  end

  // ****************************************************************
  // upstream direction
  // ****************************************************************
  // the card-side lock wire is never watched here: a card that locks
  // its own target has no path toward the initiators // RULE2

endmodule
`default_nettype wire

// [design/ltb_host.sv]
// far end: lock-owning initiator, arbiter and card-side initiator
`timescale 1ns/1ps
`default_nettype none
module ltb_host (
  // link to bridge
  ltb_if.host                                    lnk,
  // lock control
  input  wire logic                              lock_go,
  input  wire logic                              lock_done,
  output logic                                   lock_owned,
  // transaction commands
  input  wire logic                              cmd_valid,
  input  wire logic [ltb_pkg::ADDR_W-1:0]        cmd_addr,
  input  wire logic                              cmd_write,
  input  wire logic                              cmd_excl,
  output logic                                   cmd_busy,
  output logic                                   cmd_ack,
  output logic                                   cmd_retry,
  // arbiter
  input  wire logic                              complete_lock,
  input  wire logic [ltb_pkg::N_AGENTS-1:0]      agent_req,
  input  wire logic                              cache_req,
  output logic [ltb_pkg::N_AGENTS-1:0]           agent_gnt,
  output logic                                   cache_gnt,
  // card-side initiator lock
  input  wire logic                              card_lock
);

  // ****************************************************************
  // lock handshake
  // ****************************************************************
  ltb_pkg::ltb_host_state_t hstate;
  ltb_pkg::ltb_host_state_t next_hstate;
  logic [2:0]               settle;
  logic [2:0]               next_settle;
  logic                     rel_pend;
  logic                     next_rel_pend;

  always_comb begin
    next_hstate   = hstate;
    next_settle   = settle;
    next_rel_pend = rel_pend | lock_done;
    case (hstate)
      ltb_pkg::LTB_FREE: begin
        next_rel_pend = 1'b0;
        if (lock_go && lnk.lock_n) begin
          next_hstate = ltb_pkg::LTB_WAIT;
          next_settle = 3'h0;
        end
      end
      ltb_pkg::LTB_WAIT: begin
        // ownership comes from the lock handshake, not from a grant
        if (settle == ltb_pkg::SETTLE_LAST) begin
          next_hstate = ltb_pkg::LTB_OWN; // RULE5
        end else begin
          next_settle = settle + 3'h1;
        end
      end
      ltb_pkg::LTB_OWN: begin
        if (next_rel_pend && !lnk.tr_valid && !cmd_valid) begin
          next_hstate = ltb_pkg::LTB_FREE; // RULE3
        end
      end
      default: next_hstate = ltb_pkg::LTB_FREE;
    endcase
  end

  // ****************************************************************
  // transaction issue and arbitration
  // ****************************************************************
  logic                       next_valid;
  logic [ltb_pkg::ADDR_W-1:0] next_addr;
  logic                       next_write;
  logic                       next_excl;
  logic [ltb_pkg::N_AGENTS-1:0] next_agent_gnt;
  logic                       next_cache_gnt;
  logic                       owning;

  assign owning = (next_hstate != ltb_pkg::LTB_FREE);

  always_comb begin
    next_valid = lnk.tr_valid;
    next_addr  = lnk.tr_addr;
    next_write = lnk.tr_write;
    next_excl  = lnk.tr_excl;
    if (lnk.tr_valid && (lnk.tr_ack || lnk.tr_retry)) begin
      next_valid = 1'b0;
    end else if (!lnk.tr_valid && cmd_valid) begin
      next_valid = 1'b1;
      next_addr  = cmd_addr;
      next_write = cmd_write;
      next_excl  = cmd_excl & (hstate == ltb_pkg::LTB_OWN); // RULE3
    end
    next_agent_gnt = '0;
    next_cache_gnt = 1'b0;
    if (cache_req) begin
      next_cache_gnt = 1'b1; // RULE10
    end else if (complete_lock && owning) begin
      next_agent_gnt[0] = agent_req[0]; // RULE9
    end else if (agent_req[0]) begin
      next_agent_gnt[0] = 1'b1; // RULE6
    end else if (agent_req[1]) begin
      next_agent_gnt[1] = 1'b1; // RULE6
    end
  end

  always_ff @(posedge lnk.mclk) begin
    if (lnk.srst) begin
      hstate             <= ltb_pkg::LTB_FREE;
      settle             <= 3'h0;
      rel_pend           <= 1'b0;
      lnk.tr_valid       <= 1'b0;
      lnk.tr_addr        <= ltb_pkg::RST_ADDR;
      lnk.tr_write       <= 1'b0;
      lnk.tr_excl        <= 1'b0;
      lnk.host_lock_o    <= ltb_pkg::RST_PIN;
      lnk.host_lock_oe   <= 1'b0;
      lnk.card_cblock_o  <= ltb_pkg::RST_PIN;
      lnk.card_cblock_oe <= 1'b0;
      lock_owned         <= 1'b0;
      cmd_busy           <= 1'b0;
      cmd_ack            <= 1'b0;
      cmd_retry          <= 1'b0;
      agent_gnt          <= '0;
      cache_gnt          <= 1'b0;
    end else begin
      hstate             <= next_hstate;
      settle             <= next_settle;
      rel_pend           <= next_rel_pend;
      lnk.tr_valid       <= next_valid;
      lnk.tr_addr        <= next_addr;
      lnk.tr_write       <= next_write;
      lnk.tr_excl        <= next_excl;
      lnk.host_lock_o    <= 1'b0;
      lnk.host_lock_oe   <= owning;
      lnk.card_cblock_o  <= 1'b0;
      lnk.card_cblock_oe <= card_lock; // RULE13
      lock_owned         <= (next_hstate == ltb_pkg::LTB_OWN);
      cmd_busy           <= next_valid;
      cmd_ack            <= lnk.tr_valid & lnk.tr_ack;
      cmd_retry          <= lnk.tr_valid & lnk.tr_retry;
      agent_gnt          <= next_agent_gnt;
      cache_gnt          <= next_cache_gnt;
    end
  end

endmodule
`default_nettype wire

// [design/ltb_if.sv]
// link between the bridge end and the initiator/arbiter/card end
`timescale 1ns/1ps
`default_nettype none
interface ltb_if (
  input wire logic mclk,
  input wire logic srst
);
  // ****************************************************************
  // lock pin on multifunction terminal four, active low, open drain
  // ****************************************************************
  logic                       host_lock_o;
  logic                       host_lock_oe;
  logic                       lock_n;
  // ****************************************************************
  // card-side lock pin, active low, open drain
  // ****************************************************************
  logic                       dev_cblock_o;
  logic                       dev_cblock_oe;
  logic                       card_cblock_o;
  logic                       card_cblock_oe;
  logic                       cblock_n;
  // ****************************************************************
  // transaction request and answer
  // ****************************************************************
  logic                       tr_valid;
  logic [ltb_pkg::ADDR_W-1:0] tr_addr;
  logic                       tr_write;
  logic                       tr_excl;
  logic                       tr_ack;
  logic                       tr_retry;

  // wire levels with pull-ups
  assign lock_n   = ~(host_lock_oe & ~host_lock_o);
  assign cblock_n = ~((dev_cblock_oe & ~dev_cblock_o) | (card_cblock_oe & ~card_cblock_o));

  modport dev (
    input  mclk,
    input  srst,
    input  lock_n,
    input  cblock_n,
    output dev_cblock_o,
    output dev_cblock_oe,
    input  tr_valid,
    input  tr_addr,
    input  tr_write,
    input  tr_excl,
    output tr_ack,
    output tr_retry
  );
  modport host (
    input  mclk,
    input  srst,
    input  lock_n,
    input  cblock_n,
    output host_lock_o,
    output host_lock_oe,
    output card_cblock_o,
    output card_cblock_oe,
    output tr_valid,
    output tr_addr,
    output tr_write,
    output tr_excl,
    input  tr_ack,
    input  tr_retry
  );
endinterface
`default_nettype wire

// [design/ltb_pkg.sv]
// shared constants and types for the locked transaction bridge
package ltb_pkg;
  // ****************************************************************
  // widths and lock granularity
  // ****************************************************************
  localparam int ADDR_W      = 32;
  localparam int GRAN_BYTES  = 16;
  localparam int GRAN_BITS   = $clog2(GRAN_BYTES);
  localparam int REGION_W    = ADDR_W - GRAN_BITS;
  localparam int SYNC_STAGES = 3;
  localparam int N_AGENTS    = 2;
  // ****************************************************************
  // timing: lock settle before ownership, in cycles of mclk
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SETTLE_NS     = 400;
  localparam int SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] SETTLE_LAST = 3'(SETTLE_CYC - 1);
  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic                RST_PIN    = 1'b1;
  localparam logic [ADDR_W-1:0]   RST_ADDR   = 32'h0000_0000;
  localparam logic [REGION_W-1:0] RST_REGION = 28'h000_0000;
  // ****************************************************************
  // state types
  // ****************************************************************
  typedef enum logic [1:0] {
    LTB_IDLE,
    LTB_ARMED,
    LTB_HELD
  } ltb_dev_state_t;
  typedef enum logic [1:0] {
    LTB_FREE,
    LTB_WAIT,
    LTB_OWN
  } ltb_host_state_t;
endpackage
